// File: hdl/ssr_cfg.svh
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

// serial word and select field
`define SSR_WORD_W        24
`define SSR_SEL_MSB       3
`define SSR_NUM_REGS      8

// rf divider word (single select bit)
`define SSR_RFN_MSB       23
`define SSR_RFN_LSB       13
`define SSR_RFFN_MSB      12
`define SSR_RFFN_LSB      1

// rf reference and denominator word
`define SSR_RFPD_BIT      23
`define SSR_RFP_BIT       22
`define SSR_RFR_MSB       21
`define SSR_RFR_LSB       16
`define SSR_RFFD_MSB      15
`define SSR_RFFD_LSB      4

// if divider word
`define SSR_IFPD_BIT      23

// pump gain word
`define SSR_CPG_MSB       19
`define SSR_CPG_LSB       16

// modulator mode word
`define SSR_AUTO_POWER_UP_BIT      23
`define SSR_DITHER_LEVEL_MSB      17
`define SSR_DITHER_LEVEL_LSB      16
`define SSR_FM_MSB        15
`define SSR_FM_LSB        14

// fraction extension word
`define SSR_FDX_MSB       23
`define SSR_FDX_LSB       14
`define SSR_FNX_MSB       13
`define SSR_FNX_LSB       4

// reset values
`define SSR_RST_WORD      24'h000000
`define SSR_RST_MODE      24'h20C709

// divide range limits, small and large prescaler
`define SSR_P8_MIN        12'h019
`define SSR_P8_ORD2_MAX   12'h01A
`define SSR_P8_ORD3_MAX   12'h01E
`define SSR_P8_MAX        12'h3FF
`define SSR_P16_MIN       12'h031
`define SSR_P16_ORD2_MAX  12'h032
`define SSR_P16_ORD3_MAX  12'h036
`define SSR_P16_ORD3_HI   12'h7F8
`define SSR_P16_ORD2_HI   12'h7FC
`define SSR_P16_MAX       12'h7FD

`endif

// File: hdl/ssr_pkg.sv
package ssr_pkg;

    typedef logic [23:0] ssr_word_t;

    // destination register of a loaded word
    typedef enum logic [2:0] {
        SSR_RF_DIVIDER   = 3'h0,
        SSR_RF_REF_DEN   = 3'h1,
        SSR_IF_DIVIDER   = 3'h2,
        SSR_PUMP_IF_REF  = 3'h3,
        SSR_MOD_MODE     = 3'h4,
        SSR_FRAC_EXT     = 3'h5,
        SSR_FASTLOCK     = 3'h6,
        SSR_TEST_RESET   = 3'h7
    } ssr_reg_idx_t;

    // modulator order field encoding
    typedef enum logic [1:0] {
        SSR_ORD_FOURTH   = 2'h0,
        SSR_ORD_FIRST    = 2'h1,
        SSR_ORD_SECOND   = 2'h2,
        SSR_ORD_THIRD    = 2'h3
    } ssr_order_t;

endpackage

// File: hdl/ssr_regmap.sv
`timescale 1ns/10ps
`include "ssr_cfg.svh"

module ssr_regmap (
    input  wire logic        sys_clk_i,               // system clock, 250 MHz
    input  wire logic        reset_i,                 // sync reset, high
    input  wire logic        link_clk_i,              // serial clock from host
    input  wire logic        serial_data_i,           // serial data, msb first
    input  wire logic        load_strobe_i,           // load strobe pin
    input  wire logic        chip_enable_i,           // chip enable pin
    output logic [10:0]      rf_integer_divide_o,     // integer divide word
    output logic [11:0]      rf_frac_numerator_o,     // low fractional numerator
    output logic [11:0]      rf_frac_denominator_o,   // low fractional denominator
    output logic [5:0]       rf_reference_divide_o,   // rf reference divide
    output logic             rf_prescaler_select_o,   // 0: base 8, 1: base 16
    output logic [6:0]       prescaler_cycle_count_o, // C field
    output logic [1:0]       quad_step_count_o,       // B field
    output logic [1:0]       unit_step_count_o,       // A field
    output logic [11:0]      rf_divide_value_o,       // recomputed divide value
    output logic             modulator_spare_bit_o,   // spare B bit to modulator
    output logic [2:0]       modulator_order_o,       // modulator order 1..4
    output logic [1:0]       dither_level_o,          // dither strength
    output logic             frac_wide_mode_o,        // extended fraction in use
    output logic [3:0]       rf_pump_gain_o,          // rf pump gain
    output logic             if_power_down_o,         // if section down
    output logic             rf_powered_up_o,         // rf section up
    output logic             rf_range_ok_o,           // divide/order legal
    output logic             counter_restart_o,       // restart pulse on rf divider load
    output logic [7:0]       reg_written_o,           // per-register load pulse
    output logic [23:0]      reg_readback_o           // last stored word
);

    // link domain: serial shift register
    logic [`SSR_WORD_W-1:0]  shift_r;

    // sys domain
    ssr_pkg::ssr_word_t      reg_file_r [`SSR_NUM_REGS];
    ssr_pkg::ssr_word_t      load_word_r;
    logic                    strobe_lvl;
    logic                    strobe_prev_r;
    logic                    load_pend_r;
    logic                    ce_lvl;
    logic                    wr_en;
    ssr_pkg::ssr_reg_idx_t   wr_idx;
    logic                    auto_power_up_hit_r;

    logic [10:0]             n_word;
    logic                    base8;
    logic [6:0]              c_nxt;
    logic [1:0]              b_nxt;
    logic [1:0]              a_nxt;
    logic [11:0]             div_nxt;
    logic [2:0]              order_nxt;
    logic                    range_nxt;
    logic                    power_nxt;

    // last 24 bits kept
    // host holds the serial clock still while the strobe is high, so the
    // word is static when the system side copies it
    always_ff @(posedge link_clk_i) begin
        shift_r <= {shift_r[`SSR_WORD_W-2:0], serial_data_i};
    end

    ssr_sync3 u_strobe_sync (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .async_i   (load_strobe_i),
        .level_o   (strobe_lvl)
    );

    ssr_sync3 u_ce_sync (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .async_i   (chip_enable_i),
        .level_o   (ce_lvl)
    );

    // load on rising strobe
    // copy the settled word in the cycle the edge is seen, store it one cycle later
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            strobe_prev_r <= 1'b0;
            load_pend_r   <= 1'b0;
            load_word_r   <= `SSR_RST_WORD;
        end else begin
            strobe_prev_r <= strobe_lvl;
            load_pend_r   <= strobe_lvl & ~strobe_prev_r;
            if (strobe_lvl & ~strobe_prev_r) begin
                load_word_r <= shift_r;
            end
        end
    end

    // register select decode
    always_comb begin
        wr_en  = 1'b0;
        wr_idx = ssr_pkg::SSR_RF_DIVIDER;
        if (load_pend_r) begin
            if (!load_word_r[0]) begin
                wr_en  = 1'b1;
                wr_idx = ssr_pkg::SSR_RF_DIVIDER;
            end else if (load_word_r[`SSR_SEL_MSB:1] != 3'h0) begin
                wr_en  = 1'b1;
                wr_idx = ssr_pkg::ssr_reg_idx_t'(load_word_r[`SSR_SEL_MSB:1]);
            end else begin
                wr_en  = 1'b0;
            end
        end
    end

    // whole word stored, select bits included
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < `SSR_NUM_REGS; i++) begin
                reg_file_r[i] <= `SSR_RST_WORD;
            end
            reg_file_r[ssr_pkg::SSR_MOD_MODE] <= `SSR_RST_MODE;
        end else if (wr_en) begin
            reg_file_r[wr_idx] <= load_word_r;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            reg_written_o  <= 8'h00;
            reg_readback_o <= `SSR_RST_WORD;
        end else begin
            reg_written_o <= 8'h00;
            if (wr_en) begin
                reg_written_o[wr_idx] <= 1'b1;
                reg_readback_o        <= load_word_r;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            counter_restart_o <= 1'b0;
        end else begin
            counter_restart_o <= wr_en && (wr_idx == ssr_pkg::SSR_RF_DIVIDER);
        end
    end

    assign n_word = reg_file_r[ssr_pkg::SSR_RF_DIVIDER][`SSR_RFN_MSB:`SSR_RFN_LSB];

    assign base8 = ~reg_file_r[ssr_pkg::SSR_RF_REF_DEN][`SSR_RFP_BIT];

    // spare B bit freed in base-eight mode
    always_comb begin
        if (base8) begin
            c_nxt = n_word[9:3];
            b_nxt = {1'b0, n_word[2]};
        end else begin
            c_nxt = n_word[10:4];
            b_nxt = n_word[3:2];
        end
        a_nxt = n_word[1:0];
    end

    always_comb begin
        if (base8) begin
            div_nxt = {2'h0, c_nxt, 3'h0};
        end else begin
            div_nxt = {1'h0, c_nxt, 4'h0};
        end
        div_nxt = div_nxt + {8'h00, b_nxt, 2'h0} + {10'h000, a_nxt};
    end

    always_comb begin
        case (ssr_pkg::ssr_order_t'(reg_file_r[ssr_pkg::SSR_MOD_MODE][`SSR_FM_MSB:`SSR_FM_LSB]))
            ssr_pkg::SSR_ORD_FOURTH: order_nxt = 3'h4;
            ssr_pkg::SSR_ORD_FIRST:  order_nxt = 3'h1;
            ssr_pkg::SSR_ORD_SECOND: order_nxt = 3'h2;
            ssr_pkg::SSR_ORD_THIRD:  order_nxt = 3'h3;
            default:                 order_nxt = 3'h3;
        endcase
    end

    // legal range check
    // the check only reports; host bears the limits, values still load
    always_comb begin
        range_nxt = 1'b1;
        if (base8) begin
            if (div_nxt < `SSR_P8_MIN || div_nxt > `SSR_P8_MAX) begin
                range_nxt = 1'b0;
            end else if (div_nxt <= `SSR_P8_ORD2_MAX) begin
                range_nxt = (order_nxt == 3'h2);
            end else if (div_nxt <= `SSR_P8_ORD3_MAX) begin
                range_nxt = (order_nxt == 3'h2) || (order_nxt == 3'h3);
            end
        end else begin
            if (div_nxt < `SSR_P16_MIN || div_nxt > `SSR_P16_MAX) begin
                range_nxt = 1'b0;
            end else if (div_nxt <= `SSR_P16_ORD2_MAX || div_nxt >= `SSR_P16_ORD2_HI) begin
                range_nxt = (order_nxt == 3'h2);
            end else if (div_nxt <= `SSR_P16_ORD3_MAX || div_nxt >= `SSR_P16_ORD3_HI) begin
                range_nxt = (order_nxt == 3'h2) || (order_nxt == 3'h3);
            end
        end
    end

    // auto power-up latch
    // held until chip enable drops, the power-down word is rewritten or a divider load finds the auto bit clear
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            auto_power_up_hit_r <= 1'b0;
        end else if (!ce_lvl) begin
            auto_power_up_hit_r <= 1'b0;
        end else if (wr_en && wr_idx == ssr_pkg::SSR_RF_DIVIDER) begin
            auto_power_up_hit_r <= reg_file_r[ssr_pkg::SSR_MOD_MODE][`SSR_AUTO_POWER_UP_BIT];
        end else if (wr_en && wr_idx == ssr_pkg::SSR_RF_REF_DEN) begin
            auto_power_up_hit_r <= 1'b0;
        end
    end

    always_comb begin
        if (!ce_lvl) begin
            power_nxt = 1'b0;
        end else if (auto_power_up_hit_r) begin
            power_nxt = 1'b1;
        end else begin
            power_nxt = ~reg_file_r[ssr_pkg::SSR_RF_REF_DEN][`SSR_RFPD_BIT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rf_integer_divide_o     <= 11'h000;
            rf_frac_numerator_o     <= 12'h000;
            rf_frac_denominator_o   <= 12'h000;
            rf_reference_divide_o   <= 6'h00;
            rf_prescaler_select_o   <= 1'b0;
            prescaler_cycle_count_o <= 7'h00;
            quad_step_count_o       <= 2'h0;
            unit_step_count_o       <= 2'h0;
            rf_divide_value_o       <= 12'h000;
            modulator_spare_bit_o   <= 1'b0;
            modulator_order_o       <= 3'h3;
            dither_level_o          <= 2'h0;
            frac_wide_mode_o        <= 1'b0;
            rf_pump_gain_o          <= 4'h0;
            if_power_down_o         <= 1'b0;
            rf_powered_up_o         <= 1'b0;
            rf_range_ok_o           <= 1'b0;
        end else begin
            rf_integer_divide_o     <= n_word;
            rf_frac_numerator_o     <=
                reg_file_r[ssr_pkg::SSR_RF_DIVIDER][`SSR_RFFN_MSB:`SSR_RFFN_LSB];
            rf_frac_denominator_o   <=
                reg_file_r[ssr_pkg::SSR_RF_REF_DEN][`SSR_RFFD_MSB:`SSR_RFFD_LSB];
            rf_reference_divide_o   <=
                reg_file_r[ssr_pkg::SSR_RF_REF_DEN][`SSR_RFR_MSB:`SSR_RFR_LSB];
            rf_prescaler_select_o   <= ~base8;
            prescaler_cycle_count_o <= c_nxt;
            quad_step_count_o       <= b_nxt;
            unit_step_count_o       <= a_nxt;
            rf_divide_value_o       <= div_nxt;
            modulator_spare_bit_o   <= base8;
            // order and dither from mode word
            modulator_order_o       <= order_nxt;
            dither_level_o          <=
                reg_file_r[ssr_pkg::SSR_MOD_MODE][`SSR_DITHER_LEVEL_MSB:`SSR_DITHER_LEVEL_LSB];
            frac_wide_mode_o        <=
                (|reg_file_r[ssr_pkg::SSR_FRAC_EXT][`SSR_FDX_MSB:`SSR_FDX_LSB]) ||
                (|reg_file_r[ssr_pkg::SSR_FRAC_EXT][`SSR_FNX_MSB:`SSR_FNX_LSB]);
            rf_pump_gain_o          <=
                reg_file_r[ssr_pkg::SSR_PUMP_IF_REF][`SSR_CPG_MSB:`SSR_CPG_LSB];
            if_power_down_o         <=
                ~ce_lvl | reg_file_r[ssr_pkg::SSR_IF_DIVIDER][`SSR_IFPD_BIT];
            rf_powered_up_o         <= power_nxt;
            rf_range_ok_o           <= range_nxt;
        end
    end

endmodule // ssr_regmap

// File: hdl/ssr_sync3.sv
`timescale 1ns/10ps

module ssr_sync3 (
    input  wire logic sys_clk_i,  // system clock
    input  wire logic reset_i,    // sync reset, high
    input  wire logic async_i,    // foreign-domain level
    output logic      level_o     // filtered level
);

    logic meta_r;
    logic sync2_r;
    logic sync3_r;

    always_ff @(posedge sys_clk_i) begin
        meta_r  <= async_i;
        sync2_r <= meta_r;
        sync3_r <= sync2_r;
    end

    // change accepted only once stages two and three agree
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            level_o <= 1'b0;
        end else if (sync2_r == sync3_r) begin
            level_o <= sync3_r;
        end
    end

endmodule // ssr_sync3

// File: tb/ssr_host_model.sv
`timescale 1ns/10ps
module ssr_host_model (
    output logic link_clk_o, // serial clock
    output logic data_o,     // serial data
    output logic strobe_o    // load strobe
);
    initial begin
        link_clk_o = 1'b0;
        data_o     = 1'b0;
        strobe_o   = 1'b0;
    end
    task automatic send(input logic [31:0] bits, input int n);
        #1.3;
        for (int i = n - 1; i >= 0; i--) begin
            data_o <= bits[i];
            #7.5 link_clk_o <= 1'b1;
            #7.5 link_clk_o <= 1'b0;
        end
        // released line shows the inverse so a stale bit cannot pass
        data_o <= ~bits[0];
        #15 strobe_o <= 1'b1;
        #40 strobe_o <= 1'b0;
        #40;
    endtask
endmodule // ssr_host_model

// File: tb/ssr_regmap_monitor.sv
`timescale 1ns/10ps
module ssr_regmap_monitor (
    input wire logic        sys_clk_i,               // clock
    input wire logic        reset_i,                 // reset
    input wire logic        chip_enable_i,           // enable pin
    input wire logic [10:0] rf_integer_divide_o,     // n word
    input wire logic [11:0] rf_frac_numerator_o,     // numerator
    input wire logic        rf_prescaler_select_o,   // base
    input wire logic [6:0]  prescaler_cycle_count_o, // c
    input wire logic [1:0]  quad_step_count_o,       // b
    input wire logic [1:0]  unit_step_count_o,       // a
    input wire logic [11:0] rf_divide_value_o,       // divide
    input wire logic        modulator_spare_bit_o,   // spare
    input wire logic [2:0]  modulator_order_o,       // order
    input wire logic        rf_powered_up_o,         // rf up
    input wire logic        counter_restart_o,       // restart
    input wire logic [7:0]  reg_written_o,           // loads
    input wire logic [23:0] reg_readback_o           // word
);
    logic [23:0] last_word_r;
    always_ff @(posedge sys_clk_i) begin
        last_word_r <= reg_readback_o;
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_div_load;
        reg_written_o[0] ##1 !rf_prescaler_select_o;
    endsequence
    property p_restart;
        (counter_restart_o || reg_written_o[0]) |->
            (counter_restart_o && reg_written_o[0]) ##1 !counter_restart_o;
    endproperty
    a_restart: assert property (p_restart) else $error("restart pulse wrong");
    property p_onehot;
        $onehot0(reg_written_o);
    endproperty
    a_onehot: assert property (p_onehot) else $error("two loads at once");
    property p_div_fields;
        reg_written_o[0] |=> (rf_integer_divide_o == last_word_r[23:13])
            && (rf_frac_numerator_o == last_word_r[12:1]);
    endproperty
    a_div_fields: assert property (p_div_fields) else $error("divider fields wrong");
    property p_div_value;
        reg_written_o[0] |=> ##1 rf_divide_value_o ==
            ({5'h00, prescaler_cycle_count_o} << (rf_prescaler_select_o ? 4 : 3))
            + {8'h00, quad_step_count_o, 2'h0} + {10'h000, unit_step_count_o};
    endproperty
    a_div_value: assert property (p_div_value) else $error("divide value wrong");
    property p_base8;
        s_div_load |-> (prescaler_cycle_count_o == last_word_r[22:16])
            && (quad_step_count_o == {1'b0, last_word_r[15]})
            && (unit_step_count_o == last_word_r[14:13]) && modulator_spare_bit_o;
    endproperty
    a_base8: assert property (p_base8) else $error("base eight split wrong");
    property p_ce_off;
        !chip_enable_i [*6] |-> !rf_powered_up_o;
    endproperty
    a_ce_off: assert property (p_ce_off) else $error("rf up with enable low");
    property p_quiet;
        $changed(reg_readback_o) |-> (|reg_written_o);
    endproperty
    a_quiet: assert property (p_quiet) else $error("word changed without load");
    property p_order;
        reg_written_o[4] |=> modulator_order_o ==
            ((last_word_r[15:14] == 2'h0) ? 3'h4 : {1'b0, last_word_r[15:14]});
    endproperty
    a_order: assert property (p_order) else $error("modulator order wrong");
endmodule // ssr_regmap_monitor

bind ssr_regmap ssr_regmap_monitor u_monitor (
    .sys_clk_i, .reset_i, .chip_enable_i, .rf_integer_divide_o, .rf_frac_numerator_o,
    .rf_prescaler_select_o, .prescaler_cycle_count_o, .quad_step_count_o,
    .unit_step_count_o, .rf_divide_value_o, .modulator_spare_bit_o, .modulator_order_o,
    .rf_powered_up_o, .counter_restart_o, .reg_written_o, .reg_readback_o
);

// File: tb/tb_synth_serial_register_map.sv
`timescale 1ns/10ps
module tb_synth_serial_register_map;
    logic        sys_clk_i;
    logic        reset_i;
    logic        chip_enable_i;
    wire logic   link_clk;
    wire logic   serial_data;
    wire logic   load_strobe;
    logic [10:0] rf_integer_divide_o;
    logic [11:0] rf_frac_numerator_o;
    logic [11:0] rf_frac_denominator_o;
    logic [5:0]  rf_reference_divide_o;
    logic        rf_prescaler_select_o;
    logic [11:0] rf_divide_value_o;
    logic [2:0]  modulator_order_o;
    logic [1:0]  dither_level_o;
    logic        frac_wide_mode_o;
    logic [3:0]  rf_pump_gain_o;
    logic        if_power_down_o;
    logic        rf_powered_up_o;
    logic        rf_range_ok_o;
    logic        counter_restart_o;
    logic [7:0]  reg_written_o;
    logic [23:0] reg_readback_o;
    logic [31:0] seed = 32'h0000A183;
    logic [31:0] w;
    logic [23:0] prev;
    logic [10:0] n;
    logic [1:0]  ord;
    logic [8:0]  seen;
    logic [10:0] ntab [5] = '{11'h019, 11'h01A, 11'h01E, 11'h3FF, 11'h400};
    int          fails = 0;
    int          num_checks = 0;

    ssr_regmap DUT (
        .sys_clk_i, .reset_i, .link_clk_i(link_clk), .serial_data_i(serial_data),
        .load_strobe_i(load_strobe), .chip_enable_i, .rf_integer_divide_o,
        .rf_frac_numerator_o, .rf_frac_denominator_o, .rf_reference_divide_o,
        .rf_prescaler_select_o, .prescaler_cycle_count_o(), .quad_step_count_o(),
        .unit_step_count_o(), .rf_divide_value_o, .modulator_spare_bit_o(),
        .modulator_order_o, .dither_level_o, .frac_wide_mode_o, .rf_pump_gain_o,
        .if_power_down_o, .rf_powered_up_o, .rf_range_ok_o, .counter_restart_o,
        .reg_written_o, .reg_readback_o
    );
    ssr_host_model host (.link_clk_o(link_clk), .data_o(serial_data), .strobe_o(load_strobe));

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [2:0] exp_order(input logic [1:0] code);
        return (code == 2'h0) ? 3'h4 : {1'b0, code};
    endfunction
    function automatic logic exp_ok8(input logic [10:0] v, input logic [2:0] o);
        if (v < 11'h019 || v > 11'h3FF) return 1'b0;
        if (v <= 11'h01A) return o == 3'h2;
        if (v <= 11'h01E) return o == 3'h2 || o == 3'h3;
        return 1'b1;
    endfunction

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // pulse watch runs beside the frame, it lands while the strobe is high
    task automatic wr(input logic [31:0] word, input int nb, input logic want);
        seen = 9'h000;
        fork
            host.send(word, nb);
            for (int k = 0; k < 300 && seen === 9'h000; k++) begin
                @(negedge sys_clk_i);
                seen = {counter_restart_o, reg_written_o};
            end
        join
        if (want && seen === 9'h000) begin
            fails++;
            finish_test();
        end
    endtask

    initial begin
        reset_i <= 1'b1;
        chip_enable_i <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        repeat (8) @(negedge sys_clk_i);
        check({dither_level_o, frac_wide_mode_o, modulator_order_o}, 24'h3);
        for (int k = 0; k < 24; k++) begin
            w = rnd();
            w[3:0] = (k % 8 == 0) ? {w[3:1], 1'b0} : {k[2:0], 1'b1};
            wr(w, 24, 1'b1);
            check(seen, {k % 8 == 0, 8'h01 << k[2:0]});
            check(reg_readback_o, w[23:0]);
            case (k % 8)
                0: check({rf_integer_divide_o, rf_frac_numerator_o}, w[23:1]);
                1: check({rf_prescaler_select_o, rf_reference_divide_o,
                          rf_frac_denominator_o}, w[22:4]);
                2: check(if_power_down_o, w[23]);
                3: check(rf_pump_gain_o, w[19:16]);
                4: check({dither_level_o, modulator_order_o},
                         {w[17:16], exp_order(w[15:14])});
                5: check(frac_wide_mode_o, |w[23:4]);
                default: ;
            endcase
        end
        prev = w[23:0];
        w = rnd();
        w[3:0] = 4'h1;
        wr(w, 24, 1'b0);
        check(seen, 24'h000000);
        check(reg_readback_o, prev);
        w = rnd();
        w[0] = 1'b0;
        wr(w, 32, 1'b1);
        check(reg_readback_o, w[23:0]);
        $display("test decode done");
        wr(32'h00010FA3, 24, 1'b1);
        check({rf_frac_denominator_o, rf_powered_up_o}, 24'h1F5);
        for (int k = 0; k < 16; k++) begin
            // n from 25 keeps C above A and B
            n = (k < 5) ? ntab[k] : 11'(11'h01F + rnd() % 993);
            ord = (k % 2 == 1) ? 2'h3 : 2'h2;
            wr(32'h00200709 | {16'h0000, ord, 14'h0000}, 24, 1'b1);
            wr({8'h00, n, 13'h0000}, 24, 1'b1);
            check(rf_divide_value_o, {2'h0, n[9:0]});
            check(rf_range_ok_o, exp_ok8(n, exp_order(ord)));
        end
        wr(32'h00410FA3, 24, 1'b1);
        for (int k = 0; k < 4; k++) begin
            n = 11'(11'h037 + rnd() % 1985);
            wr({8'h00, n, 13'h0000}, 24, 1'b1);
            check({rf_range_ok_o, rf_divide_value_o}, {2'h2, n});
        end
        $display("test divide done");
        wr(32'h00810FA3, 24, 1'b1);
        check(rf_powered_up_o, 24'h0);
        wr(32'h00A0C709, 24, 1'b1);
        wr({8'h00, 11'h064, 13'h0000}, 24, 1'b1);
        check(rf_powered_up_o, 24'h1);
        @(posedge sys_clk_i);
        chip_enable_i <= 1'b0;
        repeat (10) @(negedge sys_clk_i);
        check({rf_powered_up_o, if_power_down_o}, 24'h1);
        @(posedge sys_clk_i);
        chip_enable_i <= 1'b1;
        repeat (10) @(negedge sys_clk_i);
        check(rf_powered_up_o, 24'h0);
        $display("test power done");
        finish_test();
    end
endmodule // tb_synth_serial_register_map
